// [rtl/pllsw_pkg.sv]
// pllsw_pkg: constants, register map and carrier types of the loop divider and
// reference switchover controller
// assumes pclk at 125 MHz stands in for the loop oscillator; analog loop is outside
`default_nettype none
package pllsw_pkg;
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned RELOCK_US     = 100;
  localparam int unsigned RELOCK_CYC    = RELOCK_US * CLK_MHZ;
  localparam int unsigned N_POST        = 10;
  localparam int unsigned N_REGIONAL    = 2;
  localparam int unsigned N_GLOBAL      = 4;
  localparam int unsigned N_EXTERNAL    = 4;
  localparam int unsigned N_INTERNAL    = 6;
  localparam int unsigned PHASE_TAPS    = 8;
  localparam int unsigned PHASE_DEG     = 45;
  localparam int unsigned DELAY_STEP_PS = 250;
  localparam int unsigned DELAY_WIN_PS  = 3000;
  localparam int          DELAY_STEPS   = DELAY_WIN_PS / DELAY_STEP_PS;
  localparam logic [10:0] PRE_MAX       = 11'h200;
  localparam logic [10:0] MUL_MAX       = 11'h200;
  localparam logic [10:0] POST_MAX      = 11'h400;
  localparam logic [10:0] POST_MAX_ODD  = 11'h200;
  localparam logic [11:0] OFS_PRE       = 12'h000;
  localparam logic [11:0] OFS_MUL       = 12'h004;
  localparam logic [11:0] OFS_CTRL      = 12'h008;
  localparam logic [11:0] OFS_STATUS    = 12'h00c;
  localparam logic [11:0] OFS_IRQ_ST    = 12'h010;
  localparam logic [11:0] OFS_IRQ_MASK  = 12'h014;
  localparam logic [11:0] OFS_SENSE     = 12'h018;
  localparam logic [11:0] OFS_POST      = 12'h020;
  localparam logic [11:0] OFS_POST_END  = 12'h048;
  localparam int unsigned POS_DIV       = 0;
  localparam int unsigned POS_NON50     = 16;
  localparam int unsigned POS_PHASE     = 17;
  localparam int unsigned POS_DELAY     = 24;
  localparam int unsigned POS_AUTO      = 0;
  localparam int unsigned POS_SOFT      = 1;
  localparam int unsigned IRQ_SWITCH    = 0;
  localparam int unsigned IRQ_LOST      = 1;
  localparam int unsigned IRQ_CFG_ERR   = 2;
  localparam int unsigned IRQ_LOCKED    = 3;
  localparam logic [9:0]  RST_PRE       = 10'h001;
  localparam logic [9:0]  RST_MUL       = 10'h001;
  localparam logic [10:0] RST_POST_DIV  = 11'h001;
  localparam logic [15:0] RST_SENSE     = 16'h0010;
  localparam logic        RST_AUTO      = 1'b1;

  typedef enum logic [1:0] {
    PLLSW_RUN   = 2'b00,
    PLLSW_DRAIN = 2'b01,
    PLLSW_SWAP  = 2'b10,
    PLLSW_ARM   = 2'b11
  } pllsw_state_type;

  typedef struct packed {
    logic [4:0]  delay;
    logic [2:0]  phase;
    logic        non50;
    logic [10:0] div;
  } pllsw_post_type;

  typedef struct packed {
    logic [9:0]                  pre;
    logic [9:0]                  mul;
    pllsw_post_type [N_POST-1:0] post;
  } pllsw_cfg_type;

  typedef struct packed {
    pllsw_cfg_type               cfg;
    logic                        auto_en;
    logic                        soft_req;
    logic [15:0]                 sense_lim;
    logic [3:0]                  irq_st;
    logic [3:0]                  irq_mask;
    logic [31:0]                 prdata;
    logic                        hit;
    logic [1:0]                  ref_s1;
    logic [1:0]                  ref_s2;
    logic [1:0]                  ref_s3;
    logic [2:0]                  req_s;
    logic [15:0]                 sense_cnt;
    logic                        prim_bad;
    logic                        sel;
    logic                        gate;
    pllsw_state_type             st;
    logic                        locked;
    logic [23:0]                 relock;
    logic [N_POST-1:0][10:0]     divcnt;
    logic [N_POST-1:0]           clko;
  } pllsw_regs_type;
endpackage
`default_nettype wire

// [rtl/pllsw_ctrl.sv]
// pllsw_ctrl: divider settings, output dividers, reference sense and glitchless
// switchover of the loop, with an apb register slave and one interrupt
// assumes reference pins and switch request are asynchronous to pclk
`default_nettype none
module pllsw_ctrl
  import pllsw_pkg::*;
#(
  parameter int unsigned RELOCK_CYCLES = RELOCK_CYC
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               reference_input_first,
  input  wire logic               reference_input_second,
  input  wire logic               clk_switch_req,
  output logic                    ref_select,
  output logic                    ref_gate_en,
  output logic                    pll_locked,
  output logic [N_REGIONAL-1:0]   clk_regional,
  output logic [N_GLOBAL-1:0]     clk_global,
  output logic [N_EXTERNAL-1:0]   clk_external,
  output pllsw_cfg_type           loop_cfg,
  output logic                    irq
);

  pllsw_regs_type s_r;
  pllsw_regs_type s_nxt;

  logic           setup;
  logic           wr;
  logic           hit;
  logic [3:0]     pidx;
  logic [31:0]    rd;
  logic [3:0]     ev;
  pllsw_post_type wpost;
  logic           first_rise;
  logic           second_rise;
  logic           req_rise;
  logic           cur_lvl;
  logic           cur_dead;
  logic           go;

  function automatic logic in_range(input logic [10:0] v, input logic [10:0] max);
    return (v != 11'h000) && (v <= max);
  endfunction

  function automatic logic post_ok(input pllsw_post_type c);
    logic [10:0] lim;
    lim = c.non50 ? POST_MAX_ODD : POST_MAX;
    return in_range(c.div, lim) &&
           ($signed(c.delay) >= $signed(5'(-DELAY_STEPS))) &&
           ($signed(c.delay) <= $signed(5'(DELAY_STEPS)));
  endfunction

  function automatic logic [31:0] post_word(input pllsw_post_type c);
    return (32'(c.div) << POS_DIV) | (32'(c.non50) << POS_NON50) |
           (32'(c.phase) << POS_PHASE) | (32'(c.delay) << POS_DELAY);
  endfunction

  function automatic logic [10:0] high_len(input pllsw_post_type c);
    logic [11:0] half;
    half = ({1'b0, c.div} + 12'h001) >> 1;
    return c.non50 ? 11'h001 : half[10:0];
  endfunction

  assign setup      = psel & ~penable;
  assign wr         = psel & penable & pwrite & hit;
  assign pidx       = 4'((paddr - OFS_POST) >> 2);
  assign wpost.div   = pwdata[POS_DIV +: 11];
  assign wpost.non50 = pwdata[POS_NON50];
  assign wpost.phase = pwdata[POS_PHASE +: 3];
  assign wpost.delay = pwdata[POS_DELAY +: 5];

  // sync stage two against stage three for edges
  assign first_rise  = s_r.ref_s2[0] & ~s_r.ref_s3[0];
  assign second_rise = s_r.ref_s2[1] & ~s_r.ref_s3[1];
  assign req_rise    = s_r.req_s[1] & ~s_r.req_s[2];
  assign cur_lvl     = s_r.sel ? s_r.ref_s2[1] : s_r.ref_s2[0];
  assign cur_dead    = ~s_r.sel & s_r.prim_bad;
  assign go = (s_r.auto_en & ~s_r.sel & s_r.prim_bad) |
              req_rise | s_r.soft_req;

  // read decode
  always_comb begin
    rd  = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == OFS_PRE) begin
      rd = {22'h00_0000, s_r.cfg.pre};
    end else if (paddr == OFS_MUL) begin
      rd = {22'h00_0000, s_r.cfg.mul};
    end else if (paddr == OFS_CTRL) begin
      rd = 32'(s_r.auto_en) << POS_AUTO;
    end else if (paddr == OFS_STATUS) begin
      rd = {26'h000_0000, s_r.st, s_r.gate, s_r.prim_bad, s_r.locked, s_r.sel};
    end else if (paddr == OFS_IRQ_ST) begin
      rd = {28'h000_0000, s_r.irq_st};
    end else if (paddr == OFS_IRQ_MASK) begin
      rd = {28'h000_0000, s_r.irq_mask};
    end else if (paddr == OFS_SENSE) begin
      rd = {16'h0000, s_r.sense_lim};
    end else if ((paddr >= OFS_POST) && (paddr < OFS_POST_END) &&
                 (paddr[1:0] == 2'b00)) begin
      rd = post_word(s_r.cfg.post[pidx]);
    end else begin
      hit = 1'b0;
    end
  end

  always_comb begin
    s_nxt = s_r;
    ev    = 4'h0;

    // apb: data latched in setup, answered in access
    if (setup) begin
      s_nxt.prdata = rd;
      s_nxt.hit    = hit;
    end
    if (wr) begin
      if (paddr == OFS_PRE) begin
        if (in_range(pwdata[10:0], PRE_MAX)) begin
          s_nxt.cfg.pre = pwdata[9:0];
          s_nxt.locked  = 1'b0;
          s_nxt.relock  = 24'h00_0000;
        end else begin
          ev[IRQ_CFG_ERR] = 1'b1;
        end
      end
      if (paddr == OFS_MUL) begin
        if (in_range(pwdata[10:0], MUL_MAX)) begin
          s_nxt.cfg.mul = pwdata[9:0];
          s_nxt.locked  = 1'b0;
          s_nxt.relock  = 24'h00_0000;
        end else begin
          ev[IRQ_CFG_ERR] = 1'b1;
        end
      end
      if (paddr == OFS_CTRL) begin
        s_nxt.auto_en  = pwdata[POS_AUTO];
        s_nxt.soft_req = pwdata[POS_SOFT] | s_r.soft_req;
      end
      if (paddr == OFS_IRQ_MASK) begin
        s_nxt.irq_mask = pwdata[3:0];
      end
      if (paddr == OFS_SENSE) begin
        s_nxt.sense_lim = pwdata[15:0];
      end
      if ((paddr >= OFS_POST) && (paddr < OFS_POST_END)) begin
        // phase tap in eighths of the oscillator period, 45 degrees each
        if (post_ok(wpost)) begin
          s_nxt.cfg.post[pidx] = wpost;
        end else begin
          ev[IRQ_CFG_ERR] = 1'b1;
        end
      end
    end

    // synchronisers for pins
    s_nxt.ref_s1 = {reference_input_second, reference_input_first};
    s_nxt.ref_s2 = s_r.ref_s1;
    s_nxt.ref_s3 = s_r.ref_s2;
    s_nxt.req_s  = {s_r.req_s[1:0], clk_switch_req};

    // primary sense counted in secondary cycles
    if (first_rise) begin
      s_nxt.sense_cnt = 16'h0000;
      s_nxt.prim_bad  = 1'b0;
    end else if (second_rise && !s_r.prim_bad) begin
      s_nxt.sense_cnt = s_r.sense_cnt + 16'h0001;
      if ((s_r.sense_cnt + 16'h0001) >= s_r.sense_lim) begin
        s_nxt.prim_bad = 1'b1;
        ev[IRQ_LOST]   = 1'b1;
      end
    end

    // switchover: gate off on a low level, swap, gate on at a low level
    unique case (s_r.st)
      PLLSW_RUN: begin
        if (go) begin
          s_nxt.soft_req = 1'b0;
          s_nxt.st       = PLLSW_DRAIN;
        end
      end
      PLLSW_DRAIN: begin
        if (!cur_lvl || cur_dead) begin
          s_nxt.gate = 1'b0;
          s_nxt.st   = PLLSW_SWAP;
        end
      end
      PLLSW_SWAP: begin
        s_nxt.sel = ~s_r.sel;
        s_nxt.st  = PLLSW_ARM;
      end
      PLLSW_ARM: begin
        if (!cur_lvl || cur_dead) begin
          s_nxt.gate     = 1'b1;
          s_nxt.locked   = 1'b0;
          s_nxt.relock   = 24'h00_0000;
          s_nxt.st       = PLLSW_RUN;
          ev[IRQ_SWITCH] = 1'b1;
        end
      end
    endcase

    // relock timer bounds time to lock on the new reference
    if (!s_r.locked && s_nxt.locked == s_r.locked && s_r.st == PLLSW_RUN) begin
      if (s_r.relock >= 24'(RELOCK_CYCLES - 1)) begin
        s_nxt.locked   = 1'b1;
        ev[IRQ_LOCKED] = 1'b1;
      end else begin
        s_nxt.relock = s_r.relock + 24'h00_0001;
      end
    end

    // post-scale dividers run from the oscillator regardless of switchover
    for (int i = 0; i < N_POST; i++) begin
      if (s_r.divcnt[i] >= (s_r.cfg.post[i].div - 11'h001)) begin
        s_nxt.divcnt[i] = 11'h000;
      end else begin
        s_nxt.divcnt[i] = s_r.divcnt[i] + 11'h001;
      end
      s_nxt.clko[i] = s_nxt.divcnt[i] < high_len(s_r.cfg.post[i]);
    end

    // sticky status: set wins over a write-one clear
    s_nxt.irq_st = s_r.irq_st;
    if (wr && paddr == OFS_IRQ_ST) begin
      s_nxt.irq_st = s_r.irq_st & ~pwdata[3:0];
    end
    s_nxt.irq_st = s_nxt.irq_st | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r           <= '0;
      s_r.cfg.pre   <= RST_PRE;
      s_r.cfg.mul   <= RST_MUL;
      for (int i = 0; i < N_POST; i++) begin
        s_r.cfg.post[i].div <= RST_POST_DIV;
      end
      s_r.auto_en   <= RST_AUTO;
      s_r.sense_lim <= RST_SENSE;
      s_r.gate      <= 1'b1;
      s_r.st        <= PLLSW_RUN;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pready       = 1'b1;
  assign pslverr      = psel & penable & ~s_r.hit;
  assign prdata       = s_r.prdata;
  assign ref_select   = s_r.sel;
  assign ref_gate_en  = s_r.gate;
  assign pll_locked   = s_r.locked;
  // divider outputs: regional, then global, then external dividers
  assign clk_regional = s_r.clko[N_REGIONAL-1:0];
  assign clk_global   = s_r.clko[N_INTERNAL-1:N_REGIONAL];
  assign clk_external = s_r.clko[N_POST-1:N_INTERNAL];
  assign loop_cfg     = s_r.cfg;
  assign irq          = |(s_r.irq_st & s_r.irq_mask);

endmodule // pllsw_ctrl
`default_nettype wire

// [test/pllsw_properties.sv]
// pllsw_props: port checks of the divider and switchover controller
// assumes a bind into pllsw_ctrl and one pclk domain
`default_nettype none
module pllsw_props
  import pllsw_pkg::*;
#(
  parameter int unsigned RELOCK_CYCLES = RELOCK_CYC
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  clk_switch_req,
  input wire logic                  ref_select,
  input wire logic                  ref_gate_en,
  input wire logic                  pll_locked,
  input wire logic [N_REGIONAL-1:0] clk_regional,
  input wire logic [N_GLOBAL-1:0]   clk_global,
  input wire pllsw_cfg_type         loop_cfg
);
  logic        post_ok;
  logic        gate_q;
  logic [23:0] lock_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // every post divider inside its duty-dependent range
  always_comb begin
    post_ok = 1'b1;
    for (int i = 0; i < N_POST; i++) begin
      if (loop_cfg.post[i].div == 11'h000 ||
          loop_cfg.post[i].div > (loop_cfg.post[i].non50 ? POST_MAX_ODD : POST_MAX)) begin
        post_ok = 1'b0;
      end
    end
  end
  // cycles since the gate came back while unlocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q   <= 1'b1;
      lock_cnt <= 24'h00_0000;
    end else begin
      gate_q <= ref_gate_en;
      if (pll_locked || (ref_gate_en && !gate_q)) lock_cnt <= 24'h00_0000;
      else lock_cnt <= lock_cnt + 24'h00_0001;
    end
  end
  pre_range_a: assert property (loop_cfg.pre inside {[10'h001:10'h200]})
    else $error("pre-scale setting out of range");
  mul_range_a: assert property (loop_cfg.mul inside {[10'h001:10'h200]})
    else $error("multiply setting out of range");
  post_range_a: assert property (post_ok)
    else $error("post-scale setting out of range");
  sel_quiet_a: assert property ($changed(ref_select) |-> !ref_gate_en && !$past(ref_gate_en))
    else $error("reference select moved while gated on");
  lock_drop_a: assert property ($rose(ref_gate_en) |-> !pll_locked)
    else $error("lock kept across a switchover");
  relock_slow_a: assert property (ref_gate_en && !pll_locked |-> lock_cnt <= RELOCK_CYCLES + 3)
    else $error("relock took too long");
  relock_early_a: assert property ($rose(pll_locked) |-> lock_cnt + 24'h00_0003 >= RELOCK_CYCLES)
    else $error("lock came back too early");
  osc_run_a: assert property ((loop_cfg.post[2].div == 11'h002) [*3] |-> $changed(clk_global[0]))
    else $error("divide by two output not toggling");
  div_one_a: assert property ((loop_cfg.post[0].div == 11'h001) [*3] |-> clk_regional[0])
    else $error("divide by one output not high");
  manual_sw_a: assert property ($rose(clk_switch_req) && ref_gate_en |-> ##[3:80] $changed(ref_select))
    else $error("manual request did not switch");
  sw_c: cover property ($changed(ref_select));
  lock_c: cover property ($rose(pll_locked));
  gate_c: cover property ($fell(ref_gate_en));
endmodule // pllsw_props
bind pllsw_ctrl pllsw_props #(.RELOCK_CYCLES(RELOCK_CYCLES)) pllsw_props_inst (
  .pclk, .presetn, .clk_switch_req, .ref_select, .ref_gate_en, .pll_locked,
  .clk_regional, .clk_global, .loop_cfg
);
`default_nettype wire

// [test/pllsw_refs_model.sv]
// pllsw_refs_model: two redundant references and the system switch logic
// assumes pclk from the bench; references are unrelated to it
`default_nettype none
module pllsw_refs_model (
  input  wire logic pclk,
  input  wire logic first_run,
  input  wire logic go,
  output var logic  ref_first,
  output var logic  ref_second,
  output var logic  clk_switch_req
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] req_cnt = 3'h0;
  initial ref_first = 1'b0;
  initial ref_second = 1'b0;
  // a stopped reference stands still low; both within the sense tolerance
  always #40 ref_first = first_run ? ~ref_first : 1'b0;
  always #44 ref_second = ~ref_second;
  // one level request per kick, rising edge is the request
  always @(posedge pclk) begin
    if (go) req_cnt <= 3'h6;
    else if (req_cnt != 3'h0) req_cnt <= req_cnt - 3'h1;
  end
  assign clk_switch_req = (req_cnt != 3'h0);
endmodule // pllsw_refs_model
`default_nettype wire

// [test/pllsw_ctrl_tb_top.sv]
// pllsw_ctrl_tb_top: register table, switchover and reset tests
// assumes the checker is bound and the reference model drives the pins
`default_nettype none
module pllsw_ctrl_tb_top;
  import pllsw_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } pllsw_row_type;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0000_0000;
  logic          first_run = 1'b1;
  logic          go = 1'b0;
  logic [31:0]   prdata, q;
  logic          pready, pslverr, e, ref_first, ref_second, clk_switch_req;
  logic          ref_select, ref_gate_en, pll_locked, irq;
  pllsw_cfg_type loop_cfg;
  int            err_total = 0;
  int            checked = 0;
  wire logic [2:0] mon = {pll_locked, ref_gate_en, ref_select};
  pllsw_row_type rows [12] = '{
    '{12'h000, 32'h0000_0200, 32'h0000_0200, 1'b0}, '{12'h000, 32'h0000_0000, 32'h0000_0200, 1'b0},
    '{12'h000, 32'h0000_0201, 32'h0000_0200, 1'b0}, '{12'h004, 32'h0000_0200, 32'h0000_0200, 1'b0},
    '{12'h004, 32'h0000_0000, 32'h0000_0200, 1'b0}, '{12'h020, 32'h0000_0400, 32'h0000_0400, 1'b0},
    '{12'h020, 32'h0000_0401, 32'h0000_0400, 1'b0}, '{12'h024, 32'h0001_0201, 32'h0000_0001, 1'b0},
    '{12'h024, 32'h0001_0200, 32'h0001_0200, 1'b0}, '{12'h028, 32'h0c0e_0002, 32'h0c0e_0002, 1'b0},
    '{12'h02c, 32'h1400_0002, 32'h1400_0002, 1'b0}, '{12'h01c, 32'h0000_0001, 32'h0000_0000, 1'b1}};
  always #4 pclk = ~pclk;
  pllsw_refs_model pllsw_refs_model_inst (.pclk(pclk), .first_run(first_run), .go(go),
    .ref_first(ref_first), .ref_second(ref_second), .clk_switch_req(clk_switch_req));
  pllsw_ctrl #(.RELOCK_CYCLES(20)) pllsw_ctrl_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_input_first(ref_first), .reference_input_second(ref_second),
    .clk_switch_req(clk_switch_req), .ref_select(ref_select), .ref_gate_en(ref_gate_en),
    .pll_locked(pll_locked), .clk_regional(), .clk_global(), .clk_external(),
    .loop_cfg(loop_cfg), .irq(irq));
  task automatic test_done();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      err_total++;
      $display("unexpected word at %0t: got %h exp %h", $time, g, x);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic x);
    checked++;
    if (g !== x) begin
      err_total++;
      $display("unexpected bit at %0t: got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
    if (n >= 50) begin
      err_total++;
      test_done();
    end
  endtask
  task automatic wait_bit(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (mon[b] !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    #1;
    cmp_bit(mon[b], v);
    if (n >= lim) test_done();
  endtask
  task automatic kick();
    @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    cmp_bit(ref_select, 1'b0);
    cmp_bit(ref_gate_en, 1'b1);
    cmp_bit(pll_locked, 1'b0);
    $display("test reset done");
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      cmp_bit(e, rows[i].e);
      if (!rows[i].e) begin
        apb(1'b0, rows[i].a, 32'h0000_0000);
        cmp_word(q, rows[i].q);
      end
    end
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0004);
    cmp_bit(irq, 1'b1);
    apb(1'b1, OFS_IRQ_ST, 32'h0000_0004);
    cmp_bit(irq, 1'b0);
    $display("test table done");
    wait_bit(2, 1'b1, 200);
    kick();
    wait_bit(0, 1'b1, 200);
    wait_bit(1, 1'b1, 200);
    wait_bit(2, 1'b1, 200);
    kick();
    wait_bit(0, 1'b0, 200);
    wait_bit(2, 1'b1, 200);
    $display("test manual done");
    apb(1'b1, OFS_SENSE, 32'h0000_0004);
    first_run <= 1'b0;
    wait_bit(0, 1'b1, 400);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    cmp_word(q & 32'h0000_0005, 32'h0000_0005);
    apb(1'b0, OFS_IRQ_ST, 32'h0000_0000);
    cmp_word(q & 32'h0000_0003, 32'h0000_0003);
    $display("test auto done");
    @(posedge pclk);
    presetn <= 1'b0;
    first_run <= 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    cmp_bit(ref_select, 1'b0);
    cmp_bit(pll_locked, 1'b0);
    $display("test mid reset done");
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    wait_bit(0, 1'b1, 200);
    wait_bit(2, 1'b1, 200);
    $display("test soft done");
    test_done();
  end
endmodule // pllsw_ctrl_tb_top
`default_nettype wire
